// [rtl/sbx_sub_exec.sv]
// Subtract instruction execution datapath with quarter-phase sequencing
//
// Notes on behaviour
// [RULE1] Literal subtract: literal minus accumulator, difference into accumulator.
// [RULE2] Literal subtract opcode has upper byte 0000 1000, literal in low byte.
// [RULE3] File subtract opcode starts 0101 11, then destination, access, address.
// [RULE4] File address spans 0 to 255; destination and access bits are single bits.
// [RULE5] Literal subtract: decode Q1, fetch literal Q2, process Q3, write Q4.
// [RULE6] File subtract: read file Q2, process Q3, write destination Q4.
// [RULE7] Both update negative, wrap, carry, half carry and zero flags.
// [RULE8] Each instruction is one word and completes in one instruction cycle.
// [RULE9] Destination 0 to accumulator, 1 to file; access 0 access bank, 1 bank pointer.
`timescale 1ns/10ps
module sbx_sub_exec
    import sbx_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    // Instruction word, sampled at the start of each instruction cycle
    input  wire logic [15:0] INSTR,
    // File register read path
    output logic      [7:0]  FILE_ADDR,
    output logic             FILE_BANKED,
    output logic             FILE_RD,
    input  wire logic [7:0]  FILE_RDATA,
    // File register write path
    output logic             FILE_WR,
    output logic      [7:0]  FILE_WDATA,
    // Architectural state
    output logic      [7:0]  ACC,
    output logic      [4:0]  FLAGS,
    output logic      [3:0]  PHASE
);
    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    sbx_phase_t  phase_ff;
    sbx_phase_t  nxt_phase;
    logic [15:0] instr_ff;
    logic [7:0]  opnd_ff;
    logic [7:0]  acc_ff;
    logic [4:0]  flags_ff;
    logic [7:0]  diff_ff;
    logic [4:0]  nflags_ff;
    logic        wr_file_ff;
    logic        wr_acc_ff;

    // ------------------------------------------------------------
    // Subtractor
    // ------------------------------------------------------------
    // Minuend plus inverted subtrahend plus one; bit 8 set means no borrow
    function automatic logic [8:0] sub_no_borrow
    (
        input logic [7:0] minuend,
        input logic [7:0] subtrahend
    );
        sub_no_borrow = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
    endfunction

    // ------------------------------------------------------------
    // Decode of the latched word
    // ------------------------------------------------------------
    // [RULE2] literal opcode match
    wire         is_lit   = (instr_ff[15:8] == LIT_SUB_OPC);
    // [RULE3] file opcode match
    wire         is_file  = (instr_ff[15:10] == FILE_SUB_OPC);
    wire         dest_f   = instr_ff[DEST_BIT];
    wire [7:0]   lit_val  = instr_ff[7:0];

    // ------------------------------------------------------------
    // Difference and flag terms
    // ------------------------------------------------------------
    // Nibbles moved to the top so one subtractor shape gives the half carry too
    wire [8:0]   full_sub = sub_no_borrow(opnd_ff, acc_ff);
    wire [8:0]   half_sub = sub_no_borrow({opnd_ff[3:0], 4'h0}, {acc_ff[3:0], 4'h0});
    wire [7:0]   diff     = full_sub[7:0];
    wire         wrap     = (opnd_ff[7] != acc_ff[7]) && (diff[7] != opnd_ff[7]);

    // ------------------------------------------------------------
    // Quarter-phase sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (phase_ff)
            SBX_Q1: nxt_phase = SBX_Q2;
            SBX_Q2: nxt_phase = SBX_Q3;
            SBX_Q3: nxt_phase = SBX_Q4;
            SBX_Q4: nxt_phase = SBX_Q1;
            default: nxt_phase = SBX_Q1;
        endcase
    end

    // [RULE8] four phases make one instruction cycle
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            phase_ff <= SBX_Q1;
        else
            phase_ff <= nxt_phase;
    end

    // ------------------------------------------------------------
    // Instruction and operand capture
    // ------------------------------------------------------------
    // [RULE5] decode latch in Q1, operand fetch in Q2
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            instr_ff <= 16'h0000;
            opnd_ff  <= 8'h00;
        end
        else
        begin
            if (phase_ff == SBX_Q1)
                instr_ff <= INSTR;
            // [RULE6] file operand read in Q2
            if (phase_ff == SBX_Q2)
                opnd_ff <= is_file ? FILE_RDATA : lit_val;
        end
    end

    // ------------------------------------------------------------
    // Process phase
    // ------------------------------------------------------------
    // [RULE7] flags computed in Q3 from the difference
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            diff_ff    <= 8'h00;
            nflags_ff  <= FLAGS_RST;
            wr_file_ff <= 1'b0;
            wr_acc_ff  <= 1'b0;
        end
        else if (phase_ff == SBX_Q3)
        begin
            diff_ff               <= diff;
            nflags_ff[FLAG_CARRY] <= full_sub[8];
            nflags_ff[FLAG_HALF]  <= half_sub[8];
            nflags_ff[FLAG_ZERO]  <= (diff == 8'h00);
            nflags_ff[FLAG_WRAP]  <= wrap;
            nflags_ff[FLAG_NEG]   <= diff[7];
            // [RULE9] destination steering
            wr_file_ff <= is_file && dest_f;
            wr_acc_ff  <= is_lit || (is_file && !dest_f);
        end
        else if (phase_ff == SBX_Q4)
        begin
            wr_file_ff <= 1'b0;
            wr_acc_ff  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Write-back
    // ------------------------------------------------------------
    // [RULE1] accumulator and flags written in Q4
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            acc_ff   <= ACC_RST;
            flags_ff <= FLAGS_RST;
        end
        else if (phase_ff == SBX_Q4)
        begin
            if (wr_acc_ff)
                acc_ff <= diff_ff;
            if (wr_acc_ff || wr_file_ff)
                flags_ff <= nflags_ff;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // [RULE4] full 8-bit address and access selector to the file
    assign FILE_ADDR   = instr_ff[7:0];
    assign FILE_BANKED = instr_ff[ACCESS_BIT];
    assign FILE_RD     = (phase_ff == SBX_Q2) && is_file;
    assign FILE_WR     = (phase_ff == SBX_Q4) && wr_file_ff;
    assign FILE_WDATA  = diff_ff;
    assign ACC         = acc_ff;
    assign FLAGS       = flags_ff;
    assign PHASE       = phase_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Fields of the word as offered, so the latch itself is checked
    wire [7:0]   req_low  = INSTR[7:0];
    wire [8:0]   req_sel  = {INSTR[ACCESS_BIT], req_low};

    sequence s_lit_issue;
        (phase_ff == SBX_Q1) ##1 is_lit;
    endsequence

    sequence s_other_issue;
        (phase_ff == SBX_Q2) && (instr_ff[15:8] != LIT_SUB_OPC)
            && (instr_ff[15:10] != FILE_SUB_OPC);
    endsequence

    a_phase_ring: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE8]
        (phase_ff == SBX_Q1) |-> ##4 (phase_ff == SBX_Q1))
        else $error("Instruction cycle is not four phases");
    a_lit_result: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE1]
        s_lit_issue |-> ##3 (acc_ff == $past(lit_val, 2) - $past(acc_ff, 2)))
        else $error("Literal subtract result wrong");
    a_lit_decode: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE2]
        (phase_ff == SBX_Q2 && instr_ff[15:8] == LIT_SUB_OPC)
        |=> (opnd_ff == $past(req_low, 2)))
        else $error("Literal not taken from the low byte");
    a_refuse_quiet: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE2]
        s_other_issue |-> ##3 ($stable(acc_ff) && $stable(flags_ff)))
        else $error("Non-subtract word changed accumulator or flags");
    a_file_decode: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE3]
        (phase_ff == SBX_Q2 && instr_ff[15:10] == FILE_SUB_OPC)
        |-> FILE_RD ##1 (opnd_ff == $past(FILE_RDATA)))
        else $error("File opcode not decoded");
    a_file_addr: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE4]
        FILE_RD |-> ({FILE_BANKED, FILE_ADDR} == $past(req_sel)))
        else $error("File address or access bit wrong");
    a_q2_read: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE6]
        FILE_RD |-> (phase_ff == SBX_Q2) ##2 (FILE_WR == instr_ff[DEST_BIT]))
        else $error("File read or write in wrong phase");
    a_q4_write: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE5]
        $changed(acc_ff) |-> ($past(phase_ff) == SBX_Q4))
        else $error("Accumulator written outside Q4");
    a_zero_flag: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE7]
        $changed(flags_ff) |-> (flags_ff[FLAG_ZERO] == ($past(diff_ff) == 8'h00)))
        else $error("Zero flag disagrees with result");
    a_dest_acc: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE9]
        FILE_WR |=> $stable(acc_ff))
        else $error("Accumulator written for file destination");
endmodule

// [rtl/sbx_pkg.sv]
// Constants and types for the subtract instruction execution block
package sbx_pkg;
    localparam logic [7:0]  LIT_SUB_OPC   = 8'h08;
    localparam logic [5:0]  FILE_SUB_OPC  = 6'h17;
    localparam int          DEST_BIT      = 9;
    localparam int          ACCESS_BIT    = 8;
    localparam logic [7:0]  ACC_RST       = 8'h00;
    localparam logic [4:0]  FLAGS_RST     = 5'h00;
    localparam int          FLAG_CARRY    = 0;
    localparam int          FLAG_HALF     = 1;
    localparam int          FLAG_ZERO     = 2;
    localparam int          FLAG_WRAP     = 3;
    localparam int          FLAG_NEG      = 4;

    typedef enum logic [3:0]
    {
        SBX_Q1 = 4'b0001,
        SBX_Q2 = 4'b0010,
        SBX_Q3 = 4'b0100,
        SBX_Q4 = 4'b1000
    } sbx_phase_t;
endpackage

// [test/sbx_file_model.sv]
// File register model facing the subtract block
`timescale 1ns/10ps
module sbx_file_model
(
    // Clock
    input  wire logic       CLOCK,
    // File access
    input  wire logic [7:0] FILE_ADDR,
    input  wire logic       FILE_BANKED,
    input  wire logic       FILE_RD,
    input  wire logic       FILE_WR,
    input  wire logic [7:0] FILE_WDATA,
    output logic      [7:0] FILE_RDATA
);
    logic [7:0] mem [512];
    logic [7:0] last_ff;
    wire  [8:0] idx = {FILE_BANKED, FILE_ADDR};
    // Released bus shows the inverse so stale data never passes
    assign FILE_RDATA = FILE_RD ? mem[idx] : ~last_ff;
    initial
    begin
        last_ff = 8'h00;
        for (int i = 0; i < 512; i++) mem[i] = 8'(i * 7 + i / 256);
    end
    always @(posedge CLOCK)
    begin
        if (FILE_RD) last_ff <= mem[idx];
        if (FILE_WR) mem[idx] <= FILE_WDATA;
    end
endmodule

// [test/tb_subtract_instruction_exec.sv]
// Self-checking bench for the subtract execution block
`timescale 1ns/10ps
module tb_subtract_instruction_exec
    import sbx_pkg::*;
;
    logic        clock, reset, file_banked, file_rd, file_wr;
    logic [15:0] instr;
    logic [7:0]  file_addr, file_rdata, file_wdata, acc, acc_m;
    logic [4:0]  flags, flg_m;
    logic [3:0]  phase;
    logic [7:0]  mem_m [512];
    int          failures, checks_done, cycles;

    sbx_sub_exec u_dut (.CLOCK(clock), .RESET(reset), .INSTR(instr), .FILE_ADDR(file_addr),
        .FILE_BANKED(file_banked), .FILE_RD(file_rd), .FILE_RDATA(file_rdata),
        .FILE_WR(file_wr), .FILE_WDATA(file_wdata), .ACC(acc), .FLAGS(flags), .PHASE(phase));
    sbx_file_model u_mem (.CLOCK(clock), .FILE_ADDR(file_addr), .FILE_BANKED(file_banked),
        .FILE_RD(file_rd), .FILE_WR(file_wr), .FILE_WDATA(file_wdata), .FILE_RDATA(file_rdata));

    always #50 clock = ~clock;
    // Hang guard, well above the roughly 72 cycles used
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            print_verdict();
        end
    end

    task print_verdict;
        if (failures == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task step;
        @(posedge clock);
        #1;
    endtask

    task automatic run(input logic [15:0] w);
        logic       lit, fil, wr;
        logic [7:0] a, d;
        lit = (w[15:8] === LIT_SUB_OPC);
        fil = (w[15:10] === FILE_SUB_OPC);
        wr  = fil && w[DEST_BIT];
        a   = lit ? w[7:0] : mem_m[w[8:0]];
        d   = a + ~acc_m + 8'h01;
        for (int i = 0; i < 9 && phase !== SBX_Q1; i++) step();
        instr = w;
        step();
        chk(file_rd, fil);
        if (fil) chk({file_banked, file_addr}, w[8:0]);
        step();
        step();
        chk(file_wr, wr);
        if (wr) chk(file_wdata, d);
        chk(acc, acc_m);
        step();
        // Carry and half carry mean no borrow
        if (lit || fil) flg_m = {d[7], a[7] != acc_m[7] && d[7] != a[7], d == 8'h00,
            a[3:0] >= acc_m[3:0], a >= acc_m};
        if (lit || (fil && !w[DEST_BIT])) acc_m = d;
        if (wr) mem_m[w[8:0]] = d;
        chk(phase, SBX_Q1);
        chk(acc, acc_m);
        chk(flags, flg_m);
    endtask

    // Zero, negative and signed wrap results in turn
    task t_literal;
        run(16'h0802);
        run(16'h0802);
        run(16'h0803);
        run(16'h0802);
        run(16'h087F);
    endtask

    // Every destination and bank pairing, then read back a write
    task t_file;
        run(16'h5C00);
        run(16'h5EFF);
        run(16'h5D10);
        run(16'h5FFF);
        run(16'h5CFF);
        run(16'h5DFF);
    endtask

    task t_refuse;
        run(16'h0900);
        run(16'h5800);
        run(16'hFFFF);
    endtask

    // Reset in the middle of an instruction, then a literal right after release
    task t_reset;
        instr = 16'h0805;
        step();
        reset = 1;
        step();
        chk(phase, SBX_Q1);
        chk(acc, ACC_RST);
        chk(flags, FLAGS_RST);
        chk(file_rd, 1'b0);
        reset = 0;
        acc_m = ACC_RST;
        flg_m = FLAGS_RST;
        run(16'h0805);
    endtask

    initial
    begin
        clock = 0;
        reset = 1;
        instr = 16'h0000;
        acc_m = ACC_RST;
        flg_m = FLAGS_RST;
        for (int i = 0; i < 512; i++) mem_m[i] = 8'(i * 7 + i / 256);
        repeat (10) @(posedge clock);
        #1 reset = 0;
        t_literal();
        t_file();
        t_refuse();
        t_reset();
        print_verdict();
    end
endmodule
